// File: design/bsc_pkg.sv
// Shared constants and carrier types for the scan identification chain
package bsc_pkg;

  // ----------------------------------------------------------------
  // Identification register
  // ----------------------------------------------------------------
  localparam int          ID_WIDTH     = 32;      // Shift and latch width
  localparam int          ID_MFR_WIDTH = 11;      // Maker field width
  localparam int          ID_PART_WIDTH = 16;     // Part field width
  localparam int          ID_VER_WIDTH = 4;       // Version field width
  localparam logic [0:0]  ID_LSB_ONE   = 1'h1;    // Fixed marker bit

  // ----------------------------------------------------------------
  // Boundary chain geometry
  // ----------------------------------------------------------------
  localparam int BSR_CELLS      = 46;             // Cells 0 to 45
  localparam int BUS_BITS       = 8;              // Multiplexed bus width
  localparam int CELL_BUS_BIT1  = 0;              // Output for bus bit one
  localparam int CELL_UPPER_EN  = 1;              // Enable for bus bits 7..1
  localparam int CELL_BUS_BIT0  = 2;              // Output for bus bit zero
  localparam int CELL_LOW_EN    = 3;              // Enable for bus bit zero
  localparam int CELL_IRQ       = 14;             // Interrupt pin output
  localparam int CELL_IRQ_EN    = 15;             // Interrupt pin enable
  localparam int CELL_SYNC      = 25;             // Transmit sync output
  localparam int CELL_SYNC_EN   = 26;             // Transmit sync enable
  localparam int CELL_BUS_TOP   = 40;             // Holds bus bit seven
  localparam int CELL_BUS_SUM   = 47;             // Cell = 47 - bit, bits 7..2
  localparam int CELL_OBS_A_LO  = 4;              // Observe cells 4..13
  localparam int CELL_OBS_A_HI  = 13;
  localparam int CELL_OBS_B_LO  = 16;             // Observe cells 16..24
  localparam int CELL_OBS_B_HI  = 24;
  localparam int CELL_OBS_C_LO  = 27;             // Observe cells 27..32
  localparam int CELL_OBS_C_HI  = 32;
  localparam int CELL_ADDR_LO   = 33;             // Address 6 at 33, 0 at 39
  localparam int ADDR_BITS      = 7;              // Observed address bits

  // Positions inside the packed observe vector
  localparam int OBS_WIDTH      = 32;
  localparam int OBS_A_LSB      = 7;              // Group A starts here
  localparam int OBS_B_LSB      = 17;             // Group B starts here
  localparam int OBS_C_LSB      = 26;             // Group C starts here

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Observe-only pins, highest cell first, address in the low bits
  typedef struct packed {
    logic       latch_or_top_addr;                // Cell 32
    logic       tx_clock_in;                      // Cell 31
    logic       tx_clock_out;                     // Cell 30
    logic       tx_neg_line_out;                  // Cell 29
    logic       tx_pos_line_out;                  // Cell 28
    logic       tx_serial_in;                     // Cell 27
    logic       rx_clock;                         // Cell 24
    logic       rx_frame_sync;                    // Cell 23
    logic       slow_tone_out;                    // Cell 22
    logic       rx_serial_out;                    // Cell 21
    logic       rx_alarm_ind;                     // Cell 20
    logic       rx_frame_loss;                    // Cell 19
    logic       tx_clock_src_sel;                 // Cell 18
    logic       rx_signal_loss;                   // Cell 17
    logic       test_reset_in;                    // Cell 16
    logic       pll_clock;                        // Cell 13
    logic       tx_rate_sel_b;                    // Cell 12
    logic       tx_rate_sel_a;                    // Cell 11
    logic       tx_float_enable;                  // Cell 10
    logic       bus_type_sel;                     // Cell 9
    logic       host_if_sel_lo;                   // Cell 8
    logic       host_if_sel_hi;                   // Cell 7
    logic       chip_sel;                         // Cell 6
    logic       read_strobe;                      // Cell 5
    logic       write_strobe;                     // Cell 4
    logic [6:0] addr_low;                         // Cells 33..39, bit 0 at 39
  } bsc_obs_s;

  // Functionally driven pins, as values or as enables
  typedef struct packed {
    logic [7:0] bus_data;                         // Multiplexed bus
    logic       irq;                              // Interrupt request
    logic       tx_frame_sync;                    // Transmit 8 kHz sync
  } bsc_pin_s;

  // Decoded test-access state, all in the test clock domain
  typedef struct packed {
    logic logic_reset;                            // Test-Logic-Reset state
    logic capture;                                // Capture-DR state
    logic shift;                                  // Shift-DR state
    logic update;                                 // Update-DR state
    logic sel_id;                                 // Identification current
    logic sel_bsr;                                // Boundary chain current
    logic drive_pins;                             // Pins follow the chain
  } bsc_ctrl_s;

endpackage

// File: design/bsc_chain.sv
// Identification register and 46-cell boundary chain with pin muxing
`timescale 1ns/1ps
// What this block does
// - ID has shift stage plus latched output.
// - ID selected by its instruction or reset.
// - Chain is 46 cells in fixed order.
// - Cell 1 enables upper bus bits.
// - Cell 2 drives bus bit zero, enable 3.
// - Cell 14 drives interrupt, enable 15.
// - Cell 25 drives transmit sync, enable 26.
// - Cells 40-45, 0 drive bus bits 7..1.
// - Cells 4-13 observe host interface inputs.
// - Cells 16-24, 27-31 observe line signals.
// - Cells 32-39 observe address, bit 0 last.
// - ID is version, part, maker, then 1.
module bsc_chain #(
  parameter logic [3:0]  ID_VERSION = 4'h0,       // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'hA5C3,   // Arbitrary value
  parameter logic [10:0] ID_MAKER   = 11'h2B7     // Arbitrary value
) (
  input  wire logic             clk_i,            // Core clock, 250 MHz
  input  wire logic             rstn_i,           // Core reset, active low
  input  wire logic             tck_i,            // Test clock
  input  wire logic             trstn_i,          // Test reset, active low
  input  wire logic             tdi_i,            // Test data in
  input  wire bsc_pkg::bsc_ctrl_s ctrl_i,         // Test-access state
  input  wire bsc_pkg::bsc_obs_s  obs_i,          // Observed pins, async
  input  wire bsc_pkg::bsc_pin_s  func_val_i,     // Core pin values
  input  wire bsc_pkg::bsc_pin_s  func_en_i,      // Core pin enables
  output logic                  tdo_o,            // Test data out
  output logic [31:0]           id_latch_o,       // Latched identification
  output bsc_pkg::bsc_pin_s       pin_o,          // Pin values
  output bsc_pkg::bsc_pin_s       pin_oe_o        // Pin enables, high drives
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER,
                                      bsc_pkg::ID_LSB_ONE};
  localparam int N = bsc_pkg::BSR_CELLS;

  logic [31:0]  obs_s1;                           // Pin sync stage one
  logic [31:0]  obs_s2;                           // Pin sync stage two
  logic [31:0]  obs_s3;                           // Pin sync stage three
  logic [31:0]  obs_st;                           // Filtered pin levels
  logic [31:0]  next_obs_st;                      // Filter next value
  logic [N-1:0] cap_c;                            // Capture word, core side
  logic [N-1:0] next_cap_c;                       // Assembled capture word
  logic [N-1:0] cap_t1;                           // Crossing stage one
  logic [N-1:0] cap_t;                            // Capture word, test side
  logic [31:0]  id_shift;                         // ID shift stage
  logic [31:0]  next_id_shift;
  logic [N-1:0] bsr_shift;                        // Chain shift stage
  logic [N-1:0] next_bsr_shift;
  logic [N-1:0] bsr_upd;                          // Chain parallel latch
  logic [N-1:0] next_bsr_upd;
  logic         bypass;                           // One-bit bypass stage
  logic         next_bypass;
  logic         drive_t;                          // Drive level, test side
  logic         upd_tgl;                          // Flips when the latch changes
  logic         next_upd_tgl;
  logic         tgl_c1;                           // Toggle sync stage one
  logic         tgl_c2;                           // Toggle sync stage two
  logic         tgl_c3;                           // Toggle edge reference
  logic         upd_load;                         // Latch word has settled
  logic [N-1:0] upd_c;                            // Latch seen by core
  logic [N-1:0] next_upd_c;
  logic         drv_c1;                           // Crossing stage one
  logic         drv_c;                            // Drive level, core side
  bsc_pkg::bsc_pin_s next_pin;                    // Pin value next
  bsc_pkg::bsc_pin_s next_pin_oe;                 // Pin enable next

  // Cell position of a bus bit
  function automatic int bus_cell(input int bit_idx);
    if (bit_idx == 0) begin
      return bsc_pkg::CELL_BUS_BIT0;
    end else if (bit_idx == 1) begin
      return bsc_pkg::CELL_BUS_BIT1;
    end else begin
      return bsc_pkg::CELL_BUS_SUM - bit_idx;
    end
  endfunction

  // Control cell that enables a bus bit
  function automatic int bus_en_cell(input int bit_idx);
    if (bit_idx == 0) begin
      return bsc_pkg::CELL_LOW_EN;
    end else begin
      return bsc_pkg::CELL_UPPER_EN;
    end
  endfunction

  // ----------------------------------------------------------------
  // Core domain: pin filtering and capture word
  // ----------------------------------------------------------------
  // A bit moves only once stages two and three agree
  assign next_obs_st = (obs_s2 & obs_s3) | (obs_st & (obs_s2 | obs_s3));

  // Three-stage sampling of the asynchronous observe pins
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      obs_s1 <= 32'h0000_0000;
      obs_s2 <= 32'h0000_0000;
      obs_s3 <= 32'h0000_0000;
      obs_st <= 32'h0000_0000;
    end else begin
      obs_s1 <= obs_i;
      obs_s2 <= obs_s1;
      obs_s3 <= obs_s2;
      obs_st <= next_obs_st;
    end
  end

  // Observe groups land on their fixed cells
  assign next_cap_c[bsc_pkg::CELL_OBS_A_HI:bsc_pkg::CELL_OBS_A_LO] =
    obs_st[bsc_pkg::OBS_B_LSB-1:bsc_pkg::OBS_A_LSB];
  assign next_cap_c[bsc_pkg::CELL_OBS_B_HI:bsc_pkg::CELL_OBS_B_LO] =
    obs_st[bsc_pkg::OBS_C_LSB-1:bsc_pkg::OBS_B_LSB];
  assign next_cap_c[bsc_pkg::CELL_OBS_C_HI:bsc_pkg::CELL_OBS_C_LO] =
    obs_st[bsc_pkg::OBS_WIDTH-1:bsc_pkg::OBS_C_LSB];

  // Address 6 sits at cell 33, address 0 at cell 39
  genvar ga;
  generate
    for (ga = 0; ga < bsc_pkg::ADDR_BITS; ga++) begin : g_addr
      assign next_cap_c[bsc_pkg::CELL_ADDR_LO + ga] =
        obs_st[bsc_pkg::ADDR_BITS - 1 - ga];
    end
  endgenerate

  // Output cells capture what the core drives, control cells its enables
  genvar gb;
  generate
    for (gb = 0; gb < bsc_pkg::BUS_BITS; gb++) begin : g_bus_cap
      assign next_cap_c[bus_cell(gb)] = func_val_i.bus_data[gb];
    end
  endgenerate
  assign next_cap_c[bsc_pkg::CELL_UPPER_EN] = func_en_i.bus_data[1];
  assign next_cap_c[bsc_pkg::CELL_LOW_EN]   = func_en_i.bus_data[0];
  assign next_cap_c[bsc_pkg::CELL_IRQ]      = func_val_i.irq;
  assign next_cap_c[bsc_pkg::CELL_IRQ_EN]   = func_en_i.irq;
  assign next_cap_c[bsc_pkg::CELL_SYNC]     = func_val_i.tx_frame_sync;
  assign next_cap_c[bsc_pkg::CELL_SYNC_EN]  = func_en_i.tx_frame_sync;

  // Register the word so the crossing sees flop outputs only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cap_c <= '0;
    end else begin
      cap_c <= next_cap_c;
    end
  end

  // ----------------------------------------------------------------
  // Test domain: capture crossing and scan registers
  // ----------------------------------------------------------------
  // Bits are independent pin levels, so per-bit sync is enough
  always_ff @(posedge tck_i or negedge trstn_i) begin
    if (!trstn_i) begin
      cap_t1 <= '0;
      cap_t  <= '0;
    end else begin
      cap_t1 <= cap_c;
      cap_t  <= cap_t1;
    end
  end

  // Identification is current by instruction or in logic reset
  wire id_sel  = ctrl_i.sel_id | ctrl_i.logic_reset;
  wire bsr_sel = ctrl_i.sel_bsr & ~ctrl_i.logic_reset;

  // ID shift: load on capture, move toward tdo on shift
  assign next_id_shift =
    (ctrl_i.capture & id_sel) ? ID_VALUE :
    (ctrl_i.shift & id_sel)   ? {tdi_i, id_shift[31:1]} :
                                id_shift;

  // Chain shift: 46 stages, cell 0 nearest tdo
  assign next_bsr_shift =
    (ctrl_i.capture & bsr_sel) ? cap_t :
    (ctrl_i.shift & bsr_sel)   ? {tdi_i, bsr_shift[N-1:1]} :
                                 bsr_shift;

  // Parallel latch clears in logic reset, so every enable drops
  assign next_bsr_upd =
    ctrl_i.logic_reset           ? '0 :
    (ctrl_i.update & bsr_sel)    ? bsr_shift :
                                   bsr_upd;

  // Any change of the latch flips the toggle, so the core knows to reload
  assign next_upd_tgl = upd_tgl ^ (next_bsr_upd != bsr_upd);

  // Bypass stage for any other instruction
  assign next_bypass = ctrl_i.capture ? 1'h0 :
                       ctrl_i.shift   ? tdi_i : bypass;

  // Scan registers; tdo shows the next lsb of the selected path
  always_ff @(posedge tck_i or negedge trstn_i) begin
    if (!trstn_i) begin
      id_shift   <= ID_VALUE;
      id_latch_o <= ID_VALUE;
      bsr_shift  <= '0;
      bsr_upd    <= '0;
      bypass     <= 1'h0;
      tdo_o      <= 1'h0;
      drive_t    <= 1'h0;
      upd_tgl    <= 1'h0;
    end else begin
      id_shift   <= next_id_shift;
      bsr_shift  <= next_bsr_shift;
      bsr_upd    <= next_bsr_upd;
      bypass     <= next_bypass;
      drive_t    <= ctrl_i.drive_pins & ~ctrl_i.logic_reset;
      upd_tgl    <= next_upd_tgl;
      // Parallel ID output only changes on update or in logic reset
      if (ctrl_i.logic_reset) begin
        id_latch_o <= ID_VALUE;
      end else if (ctrl_i.update & id_sel) begin
        id_latch_o <= id_shift;
      end
      // Path select for the serial output
      if (id_sel) begin
        tdo_o <= next_id_shift[0];
      end else if (bsr_sel) begin
        tdo_o <= next_bsr_shift[0];
      end else begin
        tdo_o <= next_bypass;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core domain: latch crossing and pin drive
  // ----------------------------------------------------------------
  // The latch word is taken whole once its toggle has settled, so pins
  // never show a half-changed word. Limitation: two latch changes closer
  // than about three core cycles are seen as one.
  assign upd_load   = tgl_c2 ^ tgl_c3;
  assign next_upd_c = upd_load ? bsr_upd : upd_c;

  // Toggle and drive level pass two flops each; the word itself is held
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_c1 <= 1'h0;
      tgl_c2 <= 1'h0;
      tgl_c3 <= 1'h0;
      upd_c  <= '0;
      drv_c1 <= 1'h0;
      drv_c  <= 1'h0;
    end else begin
      tgl_c1 <= upd_tgl;
      tgl_c2 <= tgl_c1;
      tgl_c3 <= tgl_c2;
      upd_c  <= next_upd_c;
      drv_c1 <= drive_t;
      drv_c  <= drv_c1;
    end
  end

  // Pin select: chain latch in drive mode, core otherwise
  genvar gp;
  generate
    for (gp = 0; gp < bsc_pkg::BUS_BITS; gp++) begin : g_bus_drv
      assign next_pin.bus_data[gp] =
        drv_c ? upd_c[bus_cell(gp)] : func_val_i.bus_data[gp];
      assign next_pin_oe.bus_data[gp] =
        drv_c ? upd_c[bus_en_cell(gp)] : func_en_i.bus_data[gp];
    end
  endgenerate
  assign next_pin.irq = drv_c ? upd_c[bsc_pkg::CELL_IRQ] : func_val_i.irq;
  assign next_pin_oe.irq =
    drv_c ? upd_c[bsc_pkg::CELL_IRQ_EN] : func_en_i.irq;
  assign next_pin.tx_frame_sync =
    drv_c ? upd_c[bsc_pkg::CELL_SYNC] : func_val_i.tx_frame_sync;
  assign next_pin_oe.tx_frame_sync =
    drv_c ? upd_c[bsc_pkg::CELL_SYNC_EN] : func_en_i.tx_frame_sync;

  // Pins come from flops; all released while in reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= next_pin;
      pin_oe_o <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // Assertions, test domain
  // ----------------------------------------------------------------
  a_id_capture_value: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.capture && id_sel |=> id_shift == ID_VALUE && id_shift[0])
    else $error("ID capture did not load the identification value");

  a_id_shift_move: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.shift && id_sel |=>
      id_shift == {$past(tdi_i), $past(id_shift[31:1])})
    else $error("ID shift stage did not move by one");

  a_id_latch_hold: assert property (@(posedge tck_i) disable iff (!trstn_i)
    !(ctrl_i.update && id_sel) && !ctrl_i.logic_reset |=>
      $stable(id_latch_o))
    else $error("ID latch changed without update");

  // After a shift edge tdo shows the bit that was next to the old lsb
  a_id_tdo_path: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.shift && id_sel |=> tdo_o == id_shift[0] && tdo_o == $past(id_shift[1]))
    else $error("ID not on tdo while selected");

  a_reset_id_latch: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.logic_reset |=> id_latch_o == ID_VALUE)
    else $error("Logic reset did not force the ID latch");

  a_bsr_length: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.shift && bsr_sel |=> bsr_shift[N-1] == $past(tdi_i) &&
      tdo_o == $past(bsr_shift[1]))
    else $error("Chain shift length or order wrong");

  a_bsr_capture: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.capture && bsr_sel |=> bsr_shift == $past(cap_t))
    else $error("Chain capture did not load the sampled word");

  a_ctrl_reset_off: assert property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.logic_reset |=> !bsr_upd[bsc_pkg::CELL_UPPER_EN] &&
      !bsr_upd[bsc_pkg::CELL_LOW_EN] && !bsr_upd[bsc_pkg::CELL_IRQ_EN] &&
      !bsr_upd[bsc_pkg::CELL_SYNC_EN] && !drive_t)
    else $error("Control cells not disabled by logic reset");

  // ----------------------------------------------------------------
  // Assertions, core domain; covers for both domains
  // ----------------------------------------------------------------
  a_addr_zero_cell: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ##1 cap_c[bsc_pkg::CELL_ADDR_LO + bsc_pkg::ADDR_BITS - 1] ==
      $past(obs_st[0]))
    else $error("Address bit zero not on its cell");

  a_bus_enables: assert property (@(posedge clk_i) disable iff (!rstn_i)
    drv_c |=> pin_oe_o.bus_data[0] == $past(upd_c[bsc_pkg::CELL_LOW_EN]) &&
      pin_oe_o.bus_data[7] == $past(upd_c[bsc_pkg::CELL_UPPER_EN]) &&
      pin_o.bus_data[1] == $past(upd_c[bsc_pkg::CELL_BUS_BIT1]))
    else $error("Bus pins not following their cells");

  a_irq_sync_pins: assert property (@(posedge clk_i) disable iff (!rstn_i)
    drv_c |=> pin_oe_o.irq == $past(upd_c[bsc_pkg::CELL_IRQ_EN]) &&
      pin_o.tx_frame_sync == $past(upd_c[bsc_pkg::CELL_SYNC]) &&
      pin_oe_o.tx_frame_sync == $past(upd_c[bsc_pkg::CELL_SYNC_EN]))
    else $error("Interrupt or sync pin not following its cells");

  c_id_read: cover property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.capture && ctrl_i.sel_id ##1 ctrl_i.shift [*8]);
  c_bsr_update: cover property (@(posedge tck_i) disable iff (!trstn_i)
    ctrl_i.update && bsr_sel && bsr_shift[bsc_pkg::CELL_UPPER_EN]);
  c_pins_driven: cover property (@(posedge clk_i) disable iff (!rstn_i)
    drv_c && pin_oe_o.bus_data[7]);

endmodule

// File: verification/bsc_tap_model.sv
// Scan controller model: test clock, access state and test data
`timescale 1ns/1ps
module bsc_tap_model (
  output logic               tck_o,   // Test clock, still between steps
  output bsc_pkg::bsc_ctrl_s ctrl_o,  // Access state
  output logic               tdi_o    // Test data in
);
  // ----------------------------------------------------------------
  // Idle line levels
  // ----------------------------------------------------------------
  initial begin
    tck_o  = 1'b0;
    ctrl_o = '0;
    tdi_o  = 1'b0;
  end

  // One 12 ns test clock period; inputs move at the falling edge only.
  // Rising edges land on odd nanoseconds, so they never meet a core clock edge; falling edges meet core falling edges.
  task automatic step(input bsc_pkg::bsc_ctrl_s c, input logic d);
    ctrl_o = c;
    tdi_o  = c.shift ? d : ~tdi_o;  // Unused data line toggles, never holds
    #5 tck_o = 1'b1;
    #7 tck_o = 1'b0;
  endtask
endmodule

// File: verification/tb.sv
// Self-checking bench for the scan identification chain
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] ID = {4'h3, 16'h5A1C, 11'h1D3, 1'b1}; // Arbitrary fields
  logic               clk_i  = 1'b0;  // Core clock
  logic               rstn_i = 1'b0;  // Core and test reset, active low
  logic               tck, tdi, tdo;  // Scan port
  bsc_pkg::bsc_ctrl_s ctrl, b;        // Access state, scan base state
  bsc_pkg::bsc_obs_s  obs = '0;       // Observed pins
  bsc_pkg::bsc_pin_s  fval = '0;      // Core pin values
  bsc_pkg::bsc_pin_s  fen = '0;       // Core pin enables
  bsc_pkg::bsc_pin_s  pin, pin_oe, pv, pe; // Pins and their expectations
  logic [31:0]        id_latch, r;    // Latched identification, random word
  logic [45:0]        din;            // Vector shifted in
  logic               exp_q[$];       // Expected scan output bits
  int                 n_mismatch = 0, n_compared = 0, cycles = 0, seed = 51692;

  always #2 clk_i = ~clk_i;

  bsc_tap_model tap (.tck_o(tck), .ctrl_o(ctrl), .tdi_o(tdi));
  bsc_chain #(.ID_VERSION(4'h3), .ID_PART(16'h5A1C), .ID_MAKER(11'h1D3)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .trstn_i(rstn_i), .tdi_i(tdi),
    .ctrl_i(ctrl), .obs_i(obs), .func_val_i(fval), .func_en_i(fen), .tdo_o(tdo),
    .id_latch_o(id_latch), .pin_o(pin), .pin_oe_o(pin_oe));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (!ok) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watcher takes the oldest note once the scan output has settled after a rise
  always @(posedge tck) begin
    if (ctrl.capture || ctrl.shift) begin
      #1;
      check(tdo === exp_q.pop_front(), "scan output");
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      check(1'b0, "timeout");
      finish_test();
    end
  end

  // Expected capture word, cell k at bit k
  function automatic logic [45:0] cap_of();
    logic [45:0] e;
    e = '0;
    {e[0], e[1], e[2], e[3]} = {fval.bus_data[1], fen.bus_data[1], fval.bus_data[0], fen.bus_data[0]};
    for (int i = 0; i < 10; i++) e[4 + i] = obs[7 + i];
    {e[14], e[15], e[25], e[26]} = {fval.irq, fen.irq, fval.tx_frame_sync, fen.tx_frame_sync};
    for (int i = 0; i < 9; i++) e[16 + i] = obs[17 + i];
    for (int i = 0; i < 6; i++) e[27 + i] = obs[26 + i];
    for (int i = 0; i < 7; i++) e[33 + i] = obs[6 - i];
    for (int i = 0; i < 6; i++) e[40 + i] = fval.bus_data[7 - i];
    return e;
  endfunction

  // Capture, shift n cells lsb first, then update; notes each output bit
  task automatic scan(input bsc_pkg::bsc_ctrl_s bs, input int n, input logic [45:0] c);
    bsc_pkg::bsc_ctrl_s s;
    repeat (3) tap.step(bs, 1'b0); // Pin word crosses to the test side first
    s = bs;
    s.capture = 1'b1;
    exp_q.push_back(c[0]);
    tap.step(s, 1'b0);
    s = bs;
    s.shift = 1'b1;
    for (int k = 0; k < n; k++) begin
      exp_q.push_back(k < n - 1 ? c[k + 1] : din[0]);
      tap.step(s, din[k]);
    end
    s = bs;
    s.update = 1'b1;
    tap.step(s, 1'b0);
  endtask

  task automatic new_inputs();
    @(negedge clk_i);
    r = $random(seed);
    {fval, fen} = r[19:0];
    obs = $random(seed);
    din[31:0] = $random(seed);
    r = $random(seed);
    din[45:32] = r[13:0];
    repeat (20) @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    new_inputs();
    check(pin === fval && pin_oe === fen, "pins after reset");
    b = '0;
    b.sel_id = 1'b1;
    scan(b, 32, {14'h0, ID});
    check(id_latch === din[31:0], "id latch");
    b = '0;
    scan(b, 1, 46'h0);
    b.logic_reset = 1'b1;
    tap.step(b, 1'b0);
    check(id_latch === ID, "id after logic reset");
    for (int it = 0; it < 4; it++) begin
      new_inputs();
      b = '0;
      b.sel_bsr = 1'b1;
      b.drive_pins = (it != 0); // First pass samples only, pins stay with the core
      scan(b, 46, cap_of());
      repeat (6) @(negedge clk_i);
      pv = '0;
      pe = '0;
      pv.bus_data = {din[40], din[41], din[42], din[43], din[44], din[45], din[0], din[2]};
      pe.bus_data = {{7{din[1]}}, din[3]};
      {pv.irq, pe.irq, pv.tx_frame_sync, pe.tx_frame_sync} = {din[14], din[15], din[25], din[26]};
      if (it == 0) begin
        pv = fval;
        pe = fen;
      end
      check(pin_oe === pe, "pin enables");
      check(pin === pv, "pin values");
    end
    b = '0;
    b.logic_reset = 1'b1;
    tap.step(b, 1'b0);
    repeat (6) @(negedge clk_i);
    check(pin === fval && pin_oe === fen, "pins released");
    finish_test();
  end
endmodule
